// >>> config_word_decoder.sv
// Configuration word store, decoder and reset/start-up sequencer.
// Assumes all inputs are synchronous to mclk; rst is the cold start of the model.
//
// Function
// - Word reachable only in programming mode
// - Programmed bit zero, erased bit one
// - 010 selects high-speed crystal, both pins
// - 011 external clock in, pin two GPIO
// - 100 internal oscillator, both pins GPIO
// - 101 internal oscillator, clock out pin two
// - 110 external RC, pin two GPIO
// - 111 external RC, clock out pin two
// - Power-up timer holds reset after power-up
// - Start-up timer holds reset for crystal
// - Brown-out reset extended by power-up timer
// - Brown-out enable does not enable power-up timer
// - Sleep exits on reset, watchdog, interrupt
// - Wake-reset select zero: wake resets device
// - Mode 01: software bit controls brown-out
// - Pin disabled: reset inactive, pull-up on
// - Power-up timer runs only when enabled
`timescale 1ns/1ps
module config_word_decoder
  import cwd_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_LIMIT = POWERUP_DELAY_TIMER_CYCLES,
  parameter int OST_LIMIT  = OST_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Programmer port
  input  wire logic        progMode,
  input  wire logic        progWrite,
  input  wire logic        progRead,
  input  wire logic        progErase,
  input  wire logic [13:0] progAddr,
  input  wire logic [13:0] progWrData,
  output logic      [13:0] progRdData,
  output logic             progRdValid,
  // Reset and wake sources
  input  wire logic        porPulse,
  input  wire logic        brownoutLow,
  input  wire logic        extResetPinN,
  input  wire logic        wdtReset,
  input  wire logic        wdtWake,
  input  wire logic        irqWake,
  input  wire logic        sleepReq,
  input  wire logic        swBrownoutEnable,
  // Sequencer status
  output logic             deviceResetHold,
  output logic             sleeping,
  output logic             wakeTriggeredReset,
  output logic             brownoutDetected,
  // Static controls
  output logic [13:0]      activeWord,
  output logic             watchdogForceOn,
  output logic             brownoutEnable,
  output logic             extResetPinIsInput,
  output logic             weakPullupEn,
  output logic             pgmReadoutOk,
  output logic             dataReadoutOk,
  output logic             failsafeClockMonEn,
  output logic             intExtSwitchoverEn,
  // Oscillator controls
  output logic             crystalDrive,
  output logic             extClockIn,
  output logic             intOscSel,
  output logic             extRcSel,
  output logic             clkoutOnOsc2,
  output logic             osc1IsGpio,
  output logic             osc2IsGpio
);

  localparam logic [TMR_W-1:0] POWERUP_DELAY_TIMER_LIM = TMR_W'(POWERUP_DELAY_TIMER_LIMIT);
  localparam logic [TMR_W-1:0] OST_LIM  = TMR_W'(OST_LIMIT);

  cwd_seq_e    state_ff;
  cwd_seq_e    nxt_state;
  logic [13:0] nvWord_ff;
  logic [13:0] cfg_ff;
  logic [13:0] effWord;
  logic        pwrtNeeded_ff;
  logic        bodOn;
  logic        extRstActive;
  logic        rstSource;
  logic        powerSource;
  logic        wakeEvent;
  logic        wakeReset;
  logic        pwrtDone;
  logic        ostDone;
  logic        pwrtEn;
  logic        cfgAccess;

  // ****************
  // Non-volatile word and programmer access
  // ****************
  assign cfgAccess = progMode && (progAddr == CFG_ADDR);

  always_ff @(posedge mclk) begin
    if (rst) begin
      nvWord_ff <= CFG_ERASED;
    end else if (progMode && progErase) begin
      nvWord_ff <= CFG_ERASED;
    end else if (cfgAccess && progWrite) begin
      nvWord_ff <= progWrData | CFG_UNIMPL_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      progRdData  <= RD_UNMAPPED;
      progRdValid <= 1'b0;
    end else begin
      progRdValid <= progMode && progRead;
      if (progMode && progRead) begin
        progRdData <= cfgAccess ? nvWord_ff : RD_UNMAPPED;
      end
    end
  end

  // ****************
  // Word latched while the sequencer is in SEQ_HOLD
  // ****************
  assign effWord = (state_ff == SEQ_HOLD) ? nvWord_ff : cfg_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_ff <= CFG_ERASED;
    end else if (state_ff == SEQ_HOLD) begin
      cfg_ff <= nvWord_ff;
    end
  end

  // ****************
  // Reset sources
  // ****************
  always_comb begin
    case (effWord[BOD_LSB +: 2])
      BOD_ALWAYS:   bodOn = 1'b1;
      BOD_NO_SLEEP: bodOn = (state_ff != SEQ_SLEEP);
      BOD_SOFTWARE: bodOn = swBrownoutEnable;
      default:      bodOn = 1'b0;
    endcase
  end

  assign extRstActive = effWord[EXTRST_BIT] && !extResetPinN;
  assign powerSource  = porPulse || (bodOn && brownoutLow);
  assign rstSource    = powerSource || extRstActive || wdtReset;
  assign wakeEvent    = (state_ff == SEQ_SLEEP) && (wdtWake || irqWake);
  assign wakeReset    = wakeEvent && !effWord[WAKE_BIT];
  assign pwrtEn       = !effWord[POWERUP_DELAY_TIMER_BIT];

  // ****************
  // Power-up type tracking
  // ****************
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwrtNeeded_ff <= 1'b1;
    end else if (powerSource) begin
      pwrtNeeded_ff <= 1'b1;
    end else if (state_ff == SEQ_HOLD) begin
      pwrtNeeded_ff <= pwrtNeeded_ff;
    end else if (state_ff == SEQ_RUN) begin
      pwrtNeeded_ff <= 1'b0;
    end
  end

  // ****************
  // Start-up timers
  // ****************
  cwd_delay_timer #(
    .W       (TMR_W)
  ) u_powerup_delay_timer (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (state_ff != SEQ_POWERUP_DELAY_TIMER),
    .enable  (state_ff == SEQ_POWERUP_DELAY_TIMER),
    .limit   (POWERUP_DELAY_TIMER_LIM),
    .expired (pwrtDone)
  );

  cwd_delay_timer #(
    .W       (TMR_W)
  ) u_ost (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (state_ff != SEQ_OST),
    .enable  (state_ff == SEQ_OST),
    .limit   (OST_LIM),
    .expired (ostDone)
  );

  // ****************
  // Oscillator decode
  // ****************
  cwd_osc_if oscBus ();

  cwd_osc_decode u_osc (
    .oscSelect (effWord[OSC_LSB +: 3]),
    .osc       (oscBus.src)
  );

  // ****************
  // Reset sequencer
  // ****************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SEQ_HOLD: begin
        if (!rstSource) begin
          if (pwrtEn && pwrtNeeded_ff) begin
            nxt_state = SEQ_POWERUP_DELAY_TIMER;
          end else if (oscBus.needsSettle) begin
            nxt_state = SEQ_OST;
          end else begin
            nxt_state = SEQ_RUN;
          end
        end
      end
      SEQ_POWERUP_DELAY_TIMER: begin
        if (rstSource) begin
          nxt_state = SEQ_HOLD;
        end else if (pwrtDone) begin
          nxt_state = oscBus.needsSettle ? SEQ_OST : SEQ_RUN;
        end
      end
      SEQ_OST: begin
        if (rstSource) begin
          nxt_state = SEQ_HOLD;
        end else if (ostDone) begin
          nxt_state = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (rstSource) begin
          nxt_state = SEQ_HOLD;
        end else if (sleepReq) begin
          nxt_state = SEQ_SLEEP;
        end
      end
      SEQ_SLEEP: begin
        if (rstSource || wakeReset) begin
          nxt_state = SEQ_HOLD;
        end else if (wakeEvent) begin
          nxt_state = SEQ_RUN;
        end
      end
      default: begin
        nxt_state = SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= SEQ_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************
  // Sequencer status outputs
  // ****************
  always_ff @(posedge mclk) begin
    if (rst) begin
      deviceResetHold    <= 1'b1;
      sleeping           <= 1'b0;
      wakeTriggeredReset <= 1'b0;
      brownoutDetected   <= 1'b0;
    end else begin
      deviceResetHold <= (nxt_state != SEQ_RUN) && (nxt_state != SEQ_SLEEP);
      sleeping        <= (nxt_state == SEQ_SLEEP);
      if (state_ff == SEQ_SLEEP && wakeReset && !rstSource) begin
        wakeTriggeredReset <= 1'b1;
      end else if (rstSource) begin
        wakeTriggeredReset <= 1'b0;
      end
      if (bodOn && brownoutLow) begin
        brownoutDetected <= 1'b1;
      end else if (porPulse) begin
        brownoutDetected <= 1'b0;
      end
    end
  end

  // ****************
  // Static control outputs
  // ****************
  always_ff @(posedge mclk) begin
    if (rst) begin
      activeWord         <= CFG_ERASED;
      watchdogForceOn    <= 1'b1;
      brownoutEnable     <= 1'b1;
      extResetPinIsInput <= 1'b0;
      weakPullupEn       <= 1'b0;
      pgmReadoutOk       <= 1'b1;
      dataReadoutOk      <= 1'b1;
      failsafeClockMonEn <= 1'b1;
      intExtSwitchoverEn <= 1'b1;
    end else begin
      activeWord         <= effWord;
      watchdogForceOn    <= effWord[WDT_BIT];
      brownoutEnable     <= bodOn;
      extResetPinIsInput <= !effWord[EXTRST_BIT];
      weakPullupEn       <= !effWord[EXTRST_BIT];
      pgmReadoutOk       <= nvWord_ff[PROT_PGM_BIT];
      dataReadoutOk      <= nvWord_ff[PROT_DATA_BIT];
      failsafeClockMonEn <= effWord[FSCM_BIT];
      intExtSwitchoverEn <= effWord[SWITCH_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      crystalDrive <= 1'b0;
      extClockIn   <= 1'b0;
      intOscSel    <= 1'b0;
      extRcSel     <= 1'b1;
      clkoutOnOsc2 <= 1'b1;
      osc1IsGpio   <= 1'b0;
      osc2IsGpio   <= 1'b0;
    end else begin
      crystalDrive <= oscBus.crystalDrive;
      extClockIn   <= oscBus.extClockIn;
      intOscSel    <= oscBus.internal_osc_clkout;
      extRcSel     <= oscBus.external_rc_clkout;
      clkoutOnOsc2 <= oscBus.clkoutOnOsc2;
      osc1IsGpio   <= oscBus.osc1IsGpio;
      osc2IsGpio   <= oscBus.osc2IsGpio;
    end
  end

endmodule : config_word_decoder

// >>> cwd_pkg.sv
// Constants, field layout and state encoding of the configuration word decoder.
// Assumes a single 125 MHz clock domain.
package cwd_pkg;

  // ****************
  // Configuration space
  // ****************
  localparam int          CFG_W          = 14;
  localparam logic [13:0] CFG_ADDR       = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO   = 14'h2000;
  localparam logic [13:0] CFG_SPACE_HI   = 14'h3fff;
  localparam logic [13:0] CFG_ERASED     = 14'h3fff;
  localparam logic [13:0] CFG_UNIMPL_ONE = 14'h2000;
  localparam logic [13:0] RD_UNMAPPED    = 14'h0000;

  // ****************
  // Field positions
  // ****************
  localparam int OSC_LSB       = 0;
  localparam int WDT_BIT       = 3;
  localparam int POWERUP_DELAY_TIMER_BIT      = 4;
  localparam int EXTRST_BIT    = 5;
  localparam int PROT_PGM_BIT  = 6;
  localparam int PROT_DATA_BIT = 7;
  localparam int BOD_LSB       = 8;
  localparam int SWITCH_BIT    = 10;
  localparam int FSCM_BIT      = 11;
  localparam int WAKE_BIT      = 12;

  // ****************
  // Oscillator and brown-out encodings
  // ****************
  localparam logic [2:0] OSC_LOW_POWER   = 3'h0;
  localparam logic [2:0] OSC_STD_CRYSTAL = 3'h1;
  localparam logic [2:0] OSC_HS_CRYSTAL  = 3'h2;
  localparam logic [2:0] OSC_EXT_CLOCK   = 3'h3;
  localparam logic [2:0] OSC_INT_IO      = 3'h4;
  localparam logic [2:0] OSC_INT_CLKOUT  = 3'h5;
  localparam logic [2:0] OSC_RC_IO       = 3'h6;
  localparam logic [2:0] OSC_RC_CLKOUT   = 3'h7;

  localparam logic [1:0] BOD_OFF      = 2'h0;
  localparam logic [1:0] BOD_SOFTWARE = 2'h1;
  localparam logic [1:0] BOD_NO_SLEEP = 2'h2;
  localparam logic [1:0] BOD_ALWAYS   = 2'h3;

  // ****************
  // Timing
  // ****************
  localparam int CLK_FREQ_HZ   = 125_000_000;
  localparam int POWERUP_DELAY_TIMER_TIME_MS  = 64;
  localparam int POWERUP_DELAY_TIMER_CYCLES   = POWERUP_DELAY_TIMER_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int OST_CYCLES    = 1024;
  localparam int TMR_W         = 23;

  // ****************
  // Reset sequence states
  // ****************
  typedef enum logic [2:0] {
    SEQ_HOLD  = 3'b000,
    SEQ_POWERUP_DELAY_TIMER  = 3'b001,
    SEQ_OST   = 3'b011,
    SEQ_RUN   = 3'b010,
    SEQ_SLEEP = 3'b110
  } cwd_seq_e;

endpackage : cwd_pkg

// >>> cwd_osc_if.sv
// Decoded oscillator selection passed from the decoder to the top.
// Assumes the decoder drives every field combinationally.
`timescale 1ns/1ps
interface cwd_osc_if;
  logic crystalDrive;
  logic extClockIn;
  logic internal_osc_clkout;
  logic external_rc_clkout;
  logic clkoutOnOsc2;
  logic osc1IsGpio;
  logic osc2IsGpio;
  logic needsSettle;

  modport src (output crystalDrive, extClockIn, internal_osc_clkout, external_rc_clkout,
               output clkoutOnOsc2, osc1IsGpio, osc2IsGpio, needsSettle);
  modport dst (input  crystalDrive, extClockIn, internal_osc_clkout, external_rc_clkout,
               input  clkoutOnOsc2, osc1IsGpio, osc2IsGpio, needsSettle);
endinterface : cwd_osc_if

// >>> cwd_osc_decode.sv
// Oscillator select field decoder.
// Assumes the field is stable while the result is used.
`timescale 1ns/1ps
module cwd_osc_decode
  import cwd_pkg::*;
(
  // Field
  input  wire logic [2:0] oscSelect,
  // Decoded selection
  cwd_osc_if.src          osc
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    osc.crystalDrive = 1'b0;
    osc.extClockIn   = 1'b0;
    osc.internal_osc_clkout       = 1'b0;
    osc.external_rc_clkout        = 1'b0;
    osc.clkoutOnOsc2 = 1'b0;
    osc.osc1IsGpio   = 1'b0;
    osc.osc2IsGpio   = 1'b0;
    osc.needsSettle  = 1'b0;
    case (oscSelect)
      OSC_LOW_POWER, OSC_STD_CRYSTAL: begin
        osc.crystalDrive = 1'b1;
        osc.needsSettle  = 1'b1;
      end
      OSC_HS_CRYSTAL: begin
        osc.crystalDrive = 1'b1;
        osc.needsSettle  = 1'b1;
      end
      OSC_EXT_CLOCK: begin
        osc.extClockIn   = 1'b1;
        osc.osc2IsGpio   = 1'b1;
      end
      OSC_INT_IO: begin
        osc.internal_osc_clkout       = 1'b1;
        osc.osc1IsGpio   = 1'b1;
        osc.osc2IsGpio   = 1'b1;
      end
      OSC_INT_CLKOUT: begin
        osc.internal_osc_clkout       = 1'b1;
        osc.osc1IsGpio   = 1'b1;
        osc.clkoutOnOsc2 = 1'b1;
      end
      OSC_RC_IO: begin
        osc.external_rc_clkout        = 1'b1;
        osc.osc2IsGpio   = 1'b1;
      end
      OSC_RC_CLKOUT: begin
        osc.external_rc_clkout        = 1'b1;
        osc.clkoutOnOsc2 = 1'b1;
      end
      default: begin
        osc.internal_osc_clkout       = 1'b1;
      end
    endcase
  end

endmodule : cwd_osc_decode

// >>> cwd_delay_timer.sv
// Reset delay counter: counts while enabled, flags expiry, restarts on clear.
// Assumes limit is at least one and stays stable while counting.
`timescale 1ns/1ps
module cwd_delay_timer
  import cwd_pkg::*;
#(
  parameter int W = TMR_W
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Control
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic [W-1:0] limit,
  // Status
  output logic              expired
);

  logic [W-1:0] count_ff;
  logic         expired_ff;

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst || clear) begin
      count_ff   <= '0;
      expired_ff <= 1'b0;
    end else if (enable && !expired_ff) begin
      count_ff   <= count_ff + 1'b1;
      expired_ff <= (count_ff + 1'b1) >= limit;
    end
  end

  assign expired = expired_ff;

endmodule : cwd_delay_timer

// >>> cwd_monitor.sv
// Concurrent checks on the configuration word decoder ports.
// Assumes it is bound into config_word_decoder; one mclk domain.
`timescale 1ns/1ps
module cwd_monitor
  import cwd_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_LIMIT = POWERUP_DELAY_TIMER_CYCLES,
  parameter int OST_LIMIT  = OST_CYCLES
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Programmer port
  input wire logic        progMode,
  input wire logic        progRead,
  input wire logic [13:0] progAddr,
  input wire logic [13:0] progRdData,
  input wire logic        progRdValid,
  // Sources
  input wire logic        porPulse,
  input wire logic        wdtWake,
  input wire logic        irqWake,
  // Status and controls
  input wire logic        deviceResetHold,
  input wire logic        sleeping,
  input wire logic        wakeTriggeredReset,
  input wire logic [13:0] activeWord,
  input wire logic        watchdogForceOn,
  input wire logic        extResetPinIsInput,
  input wire logic        weakPullupEn,
  input wire logic        crystalDrive,
  input wire logic        extClockIn,
  input wire logic        intOscSel,
  input wire logic        extRcSel,
  input wire logic        clkoutOnOsc2,
  input wire logic        osc1IsGpio,
  input wire logic        osc2IsGpio
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire [6:0] oscVec = {crystalDrive, extClockIn, intOscSel, extRcSel, clkoutOnOsc2,
                       osc1IsGpio, osc2IsGpio};
  sequence s_por_release;
    $fell(porPulse) && !activeWord[POWERUP_DELAY_TIMER_BIT];
  endsequence
  sequence s_wake_event;
    sleeping && (irqWake || wdtWake);
  endsequence
  property p_osc(logic [2:0] code, logic [6:0] vec);
    $stable(activeWord) && activeWord[2:0] == code |-> oscVec == vec;
  endproperty
  a_osc_hs: assert property (p_osc(OSC_HS_CRYSTAL, 7'h40))
    else $error("high-speed crystal decode wrong");
  a_osc_ext_clock: assert property (p_osc(OSC_EXT_CLOCK, 7'h21))
    else $error("external clock decode wrong");
  a_osc_int_io: assert property (p_osc(OSC_INT_IO, 7'h13))
    else $error("internal oscillator io decode wrong");
  a_osc_int_clkout: assert property (p_osc(OSC_INT_CLKOUT, 7'h16))
    else $error("internal oscillator clock out decode wrong");
  a_osc_rc_io: assert property (p_osc(OSC_RC_IO, 7'h09))
    else $error("external rc io decode wrong");
  a_osc_rc_clkout: assert property (p_osc(OSC_RC_CLKOUT, 7'h0c))
    else $error("external rc clock out decode wrong");
  a_watchdog_force: assert property ($stable(activeWord) |->
    watchdogForceOn == activeWord[WDT_BIT]) else $error("watchdog force wrong");
  a_pin_pullup: assert property ($stable(activeWord) |->
    weakPullupEn == !activeWord[EXTRST_BIT] && extResetPinIsInput == !activeWord[EXTRST_BIT])
    else $error("reset pin function wrong");
  a_powerup_delay_timer_hold: assert property (s_por_release |=> deviceResetHold [*8])
    else $error("power-up delay too short");
  a_wake_resume: assert property (s_wake_event ##0 activeWord[WAKE_BIT]
    |-> ##[1:2] !sleeping) else $error("sleep not left on wake");
  a_wake_reset: assert property (s_wake_event ##0 !activeWord[WAKE_BIT]
    |-> ##[1:2] (wakeTriggeredReset && deviceResetHold)) else $error("wake reset missing");
  a_read_unmapped: assert property (progMode && progRead && progAddr != CFG_ADDR
    |=> progRdValid && progRdData == RD_UNMAPPED) else $error("unmapped read wrong");
  a_read_refused: assert property (!(progMode && progRead) |=> !progRdValid)
    else $error("read answered without request");
endmodule : cwd_monitor

bind config_word_decoder cwd_monitor #(.POWERUP_DELAY_TIMER_LIMIT(POWERUP_DELAY_TIMER_LIMIT), .OST_LIMIT(OST_LIMIT))
  u_cwd_monitor (.mclk(mclk), .rst(rst), .progMode(progMode), .progRead(progRead),
  .progAddr(progAddr), .progRdData(progRdData), .progRdValid(progRdValid),
  .porPulse(porPulse), .wdtWake(wdtWake), .irqWake(irqWake),
  .deviceResetHold(deviceResetHold), .sleeping(sleeping),
  .wakeTriggeredReset(wakeTriggeredReset), .activeWord(activeWord),
  .watchdogForceOn(watchdogForceOn), .extResetPinIsInput(extResetPinIsInput),
  .weakPullupEn(weakPullupEn), .crystalDrive(crystalDrive), .extClockIn(extClockIn),
  .intOscSel(intOscSel), .extRcSel(extRcSel), .clkoutOnOsc2(clkoutOnOsc2),
  .osc1IsGpio(osc1IsGpio), .osc2IsGpio(osc2IsGpio));

// >>> cwd_prog_model.sv
// Device programmer model driving the configuration port.
// Assumes requests are taken on the rising edge of mclk.
`timescale 1ns/1ps
module cwd_prog_model (
  // Clock
  input  wire logic  mclk,
  // Programmer port
  output logic        progMode,
  output logic        progWrite,
  output logic        progRead,
  output logic        progErase,
  output logic [13:0] progAddr,
  output logic [13:0] progWrData
);
  // ****************
  // Requests
  // ****************
  initial begin
    progMode   = 1'b0;
    progWrite  = 1'b0;
    progRead   = 1'b0;
    progErase  = 1'b0;
    progAddr   = 14'h0000;
    progWrData = 14'h0000;
  end
  // One-cycle request; kind is erase, read, write; mode and kind released low, address and data released inverted
  task automatic req(input logic [2:0] kind, input logic [13:0] addr,
                     input logic [13:0] data, input logic mode);
    @(negedge mclk);
    progMode = mode;
    {progErase, progRead, progWrite} = kind;
    progAddr = addr;
    progWrData = data;
    @(negedge mclk);
    progMode = 1'b0;
    {progErase, progRead, progWrite} = 3'b000;
    progAddr = ~addr;
    progWrData = ~data;
  endtask : req
endmodule : cwd_prog_model

// >>> tb_top.sv
// Self-checking bench for the configuration word decoder.
// Assumes cwd_pkg, design, programmer model and monitor are compiled first.
`timescale 1ns/1ps
module tb_top
  import cwd_pkg::*;
;
  // ****************
  // Stimulus and checking
  // ****************
  localparam int POWERUP_DELAY_TIMER_SIM = 20;
  localparam int OST_SIM  = 8;
  localparam logic [55:0] OSC_TAB = {7'h0c, 7'h09, 7'h16, 7'h13, 7'h21, 7'h40, 7'h40, 7'h40};
  logic mclk, rst, porPulse, brownoutLow, extResetPinN, wdtReset, wdtWake, irqWake;
  logic sleepReq, swBrownoutEnable, progMode, progWrite, progRead, progErase, progRdValid;
  logic deviceResetHold, sleeping, wakeTriggeredReset, brownoutDetected, watchdogForceOn;
  logic brownoutEnable, extResetPinIsInput, weakPullupEn, pgmReadoutOk, dataReadoutOk;
  logic failsafeClockMonEn, intExtSwitchoverEn, crystalDrive, extClockIn, intOscSel;
  logic extRcSel, clkoutOnOsc2, osc1IsGpio, osc2IsGpio;
  logic [13:0] progAddr, progWrData, progRdData, activeWord, w;
  logic [13:0] expQ [$];
  logic [31:0] seed = 32'h0000_5eb3;
  int          failCount = 0;
  int          cmpCount = 0;
  int          n;
  wire  [6:0]  oscVec = {crystalDrive, extClockIn, intOscSel, extRcSel, clkoutOnOsc2,
                         osc1IsGpio, osc2IsGpio};

  config_word_decoder #(.POWERUP_DELAY_TIMER_LIMIT(POWERUP_DELAY_TIMER_SIM), .OST_LIMIT(OST_SIM)) u_config_word_decoder (
    .mclk(mclk), .rst(rst), .progMode(progMode), .progWrite(progWrite),
    .progRead(progRead), .progErase(progErase), .progAddr(progAddr),
    .progWrData(progWrData), .progRdData(progRdData), .progRdValid(progRdValid),
    .porPulse(porPulse), .brownoutLow(brownoutLow), .extResetPinN(extResetPinN),
    .wdtReset(wdtReset), .wdtWake(wdtWake), .irqWake(irqWake), .sleepReq(sleepReq),
    .swBrownoutEnable(swBrownoutEnable), .deviceResetHold(deviceResetHold),
    .sleeping(sleeping), .wakeTriggeredReset(wakeTriggeredReset),
    .brownoutDetected(brownoutDetected), .activeWord(activeWord),
    .watchdogForceOn(watchdogForceOn), .brownoutEnable(brownoutEnable),
    .extResetPinIsInput(extResetPinIsInput), .weakPullupEn(weakPullupEn),
    .pgmReadoutOk(pgmReadoutOk), .dataReadoutOk(dataReadoutOk),
    .failsafeClockMonEn(failsafeClockMonEn), .intExtSwitchoverEn(intExtSwitchoverEn),
    .crystalDrive(crystalDrive), .extClockIn(extClockIn), .intOscSel(intOscSel),
    .extRcSel(extRcSel), .clkoutOnOsc2(clkoutOnOsc2), .osc1IsGpio(osc1IsGpio),
    .osc2IsGpio(osc2IsGpio));
  cwd_prog_model u_cwd_prog_model (.mclk(mclk), .progMode(progMode),
    .progWrite(progWrite), .progRead(progRead), .progErase(progErase),
    .progAddr(progAddr), .progWrData(progWrData));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic [13:0] mk(input logic [2:0] osc, input logic pw,
                                     input logic [1:0] brownout_detector, input logic wake);
    seed = xs(seed);
    return {1'b1, wake, seed[1:0], brownout_detector, seed[3:2], 1'b1, pw, seed[4], osc};
  endfunction : mk
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    cmpCount++;
    if (g !== e) begin
      failCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic printVerdict();
    if (failCount == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : printVerdict
  task automatic rd(input logic [13:0] a, input logic [13:0] e);
    expQ.push_back(e);
    u_cwd_prog_model.req(3'b010, a, 14'h0000, 1'b1);
  endtask : rd
  // Program a word while held in power-on reset, then check the decode
  task automatic cfg(input logic [13:0] x);
    @(negedge mclk);
    porPulse = 1'b1;
    w = x | CFG_UNIMPL_ONE;
    u_cwd_prog_model.req(3'b001, CFG_ADDR, x, 1'b1);
    rd(CFG_ADDR, w);
    repeat (3) @(negedge mclk);
    chk("activeWord", w, activeWord);
    chk("oscillator", OSC_TAB[int'(w[2:0]) * 7 +: 7], oscVec);
    chk("watchdogForceOn", w[3], watchdogForceOn);
    chk("pinFunction", {~w[5], ~w[5]}, {weakPullupEn, extResetPinIsInput});
    chk("readoutOk", w[7:6], {dataReadoutOk, pgmReadoutOk});
    chk("clockMonitors", w[11:10], {failsafeClockMonEn, intExtSwitchoverEn});
  endtask : cfg
  // Drop the supply sources and count cycles until the device runs
  task automatic powerUp(input int lo, input int hi);
    @(negedge mclk);
    porPulse = 1'b0;
    brownoutLow = 1'b0;
    n = 0;
    while (deviceResetHold !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 200) begin
      failCount++;
      printVerdict();
    end
    chk("startDelay", 14'h0001, 14'(n >= lo && n <= hi));
  endtask : powerUp
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    repeat (2) @(negedge mclk);
    s = 1'b0;
  endtask : pulse

  always @(negedge mclk) begin
    if (progRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        chk("progRdValid", 14'h0000, 14'h0001);
      end else begin
        chk("progRdData", expQ.pop_front(), progRdData);
      end
    end
  end

  initial begin
    rst = 1'b1;
    porPulse = 1'b1;
    brownoutLow = 1'b0;
    extResetPinN = 1'b1;
    wdtReset = 1'b0;
    wdtWake = 1'b0;
    irqWake = 1'b0;
    sleepReq = 1'b0;
    swBrownoutEnable = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    chk("erasedWord", CFG_ERASED, activeWord);
    for (int c = 0; c < 8; c++) begin
      cfg(mk(3'(c), 1'b1, BOD_OFF, 1'b1));
    end
    u_cwd_prog_model.req(3'b010, CFG_ADDR, 14'h0000, 1'b0);
    u_cwd_prog_model.req(3'b001, CFG_ADDR, 14'h0000, 1'b0);
    rd(CFG_ADDR, w);
    rd(seed[13:0] & 14'h3ff0, RD_UNMAPPED);
    u_cwd_prog_model.req(3'b101, CFG_ADDR, 14'h0000, 1'b1);
    rd(CFG_ADDR, CFG_ERASED);
    cfg(mk(OSC_HS_CRYSTAL, 1'b0, BOD_OFF, 1'b1));
    powerUp(POWERUP_DELAY_TIMER_SIM + OST_SIM, POWERUP_DELAY_TIMER_SIM + OST_SIM + 6);
    cfg(mk(OSC_HS_CRYSTAL, 1'b1, BOD_OFF, 1'b1));
    powerUp(OST_SIM, OST_SIM + 6);
    cfg(mk(OSC_INT_IO, 1'b0, BOD_ALWAYS, 1'b1));
    powerUp(POWERUP_DELAY_TIMER_SIM, POWERUP_DELAY_TIMER_SIM + 6);
    pulse(brownoutLow);
    chk("brownoutDetected", 14'h0001, brownoutDetected);
    powerUp(POWERUP_DELAY_TIMER_SIM, POWERUP_DELAY_TIMER_SIM + 6);
    cfg(mk(OSC_INT_IO, 1'b1, BOD_ALWAYS, 1'b1));
    powerUp(0, 4);
    pulse(brownoutLow);
    powerUp(0, 4);
    cfg(mk(OSC_INT_IO, 1'b1, BOD_SOFTWARE, 1'b1));
    powerUp(0, 4);
    for (int b = 1; b >= 0; b--) begin
      swBrownoutEnable = 1'(b);
      repeat (3) @(negedge mclk);
      chk("brownoutEnable", 14'(b), brownoutEnable);
    end
    pulse(extResetPinN);
    cfg(mk(OSC_INT_IO, 1'b1, BOD_OFF, 1'b1) & 14'h3fdf);
    powerUp(0, 4);
    extResetPinN = 1'b0;
    repeat (3) @(negedge mclk);
    chk("deviceResetHold", 14'h0000, deviceResetHold);
    extResetPinN = 1'b1;
    cfg(mk(OSC_INT_IO, 1'b1, BOD_OFF, 1'b1));
    powerUp(0, 4);
    pulse(sleepReq);
    chk("sleeping", 14'h0001, sleeping);
    pulse(irqWake);
    chk("awake", 14'h0000, {sleeping, deviceResetHold});
    cfg(mk(OSC_INT_IO, 1'b1, BOD_OFF, 1'b0));
    powerUp(0, 4);
    pulse(sleepReq);
    pulse(wdtWake);
    chk("wakeTriggeredReset", 14'h0001, wakeTriggeredReset);
    printVerdict();
  end
endmodule : tb_top
